// [hdl/tcwq_top.sv]
// Summary of operation
// R1 - Observation time split into 500 us batches
// R2 - Host gives ORx ten percent of Tx
// R3 - Host gives twenty percent in half TDD
// R4 - Host assigns time in 500 us multiples
// R5 - Enable high at least 500 us
// R6 - Enable low at least 500 us
// R7 - Short enable periods discard their observations
// R8 - Device picks feedback path itself
// R9 - Host provides external feedback path
// R10 - Rx and ORx tracking use traffic
// R11 - Host time-shares ORx path
// R12 - Rx QEC only while a receiver enabled
// R13 - Single enabled Rx channel tracked alone
// R14 - Host enables HD2 on supported profiles only
// R15 - HD2 watches band on carrier side
// R16 - Side 0 lower, 1 upper
// R17 - HD2 runs only while receivers enabled
// R18 - ORx QEC runs while ORx active
// R19 - Single enabled ORx channel tracked alone
// R20 - Intervals measured with own clock counter
`timescale 1ns/1ps
module tcwq_top
  import tcwq_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] rx_enable, // Receiver channel enable pins
  input wire logic [1:0] tx_enable, // Transmitter enable pins
  input wire logic [1:0] orx_enable, // Observation enable pins
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [1:0] rx_qec_run, // Per-channel Rx QEC gate
  output logic [1:0] hd2_run, // Per-channel HD2 gate
  output logic [1:0] orx_qec_run, // Per-channel ORx QEC gate
  output logic hd2_upper_side, // Band side for HD2 correction
  output logic [2:0] batch_done, // Pulse: good batch (rx, tx, orx)
  output logic [2:0] batch_discard, // Pulse: short high or short preceding low (rx, tx, orx)
  output logic [1:0] fb_source // Feedback paths offered (internal, orx)
);

  // Six pins synchronised as one vector: rx[1:0], tx[3:2], orx[5:4]
  logic [5:0] pin_meta_q;
  logic [5:0] pin_q;
  logic [5:0] pin_raw;
  assign pin_raw = {orx_enable, tx_enable, rx_enable};

  // Two-stage synchroniser; first stage read only by the second
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_meta_q <= '0;
      pin_q <= '0;
    end else begin
      pin_meta_q <= pin_raw;
      pin_q <= pin_meta_q;
    end
  end

  // Control register
  logic [3:0] ctrl_q;
  logic [15:0] batch_cnt_q [3]; // Good batch counters per path
  logic [15:0] discard_cnt_q [3]; // Discard counters per path
  logic [2:0] qual_q; // Qualified (long-enough) state per path
  logic [2:0] pend_disc; // Discard events this cycle
  logic [2:0] pend_batch; // Batch events this cycle

  // Per-path qualifier: path 0 rx, 1 tx, 2 orx
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_path
      logic en_any;
      logic en_prev_q;
      logic [CNT_W-1:0] hi_cnt_q; // High interval length
      logic [CNT_W-1:0] lo_cnt_q; // Low interval length
      logic [CNT_W-1:0] bat_cnt_q; // Cycles into current batch
      logic low_ok_q; // Preceding low long enough
      logic fall;
      logic rise;
      logic hi_ok;
      logic bat_end;
      assign en_any = pin_q[2*g] | pin_q[2*g+1];
      assign fall = en_prev_q & ~en_any;
      assign rise = ~en_prev_q & en_any;
      // Long enough high once counter reaches the minimum
      assign hi_ok = hi_cnt_q >= CNT_W'(ENABLE_HIGH_MIN_CYC); // [R5] [R20]
      assign bat_end = en_any & low_ok_q & (bat_cnt_q == CNT_W'(BATCH_CYC - 1)); // [R1]
      // Short high or short preceding low spoils the period
      assign pend_disc[g] = fall & (~hi_ok | ~low_ok_q); // [R7] [R6]
      assign pend_batch[g] = bat_end;
      assign qual_q[g] = en_any & low_ok_q & hi_ok;

      // Interval counters on the core clock, saturating
      always_ff @(posedge clock) begin
        if (rst) begin
          en_prev_q <= 1'b0;
          hi_cnt_q <= '0;
          bat_cnt_q <= '0;
          // Low time before the first rise counts as long enough [R6]
          lo_cnt_q <= CNT_W'(ENABLE_LOW_MIN_CYC);
          low_ok_q <= 1'b1;
        end else begin
          en_prev_q <= en_any;
          if (en_any) begin
            // Counting high time [R20]
            hi_cnt_q <= (rise || hi_ok) ? (rise ? CNT_W'(1) : hi_cnt_q) : hi_cnt_q + 1'b1;
            lo_cnt_q <= '0;
            bat_cnt_q <= (rise || bat_end) ? '0 : bat_cnt_q + 1'b1;
          end else begin
            hi_cnt_q <= '0;
            bat_cnt_q <= '0;
            if (lo_cnt_q < CNT_W'(ENABLE_LOW_MIN_CYC)) begin
              lo_cnt_q <= lo_cnt_q + 1'b1;
            end
          end
          // Low width judged at the rise; reset counts as long low [R6]
          if (rise) begin
            low_ok_q <= lo_cnt_q >= CNT_W'(ENABLE_LOW_MIN_CYC);
          end
        end
      end

      // Batch and discard never coincide: a batch needs the enable high,
      // a discard needs its fall, so one else-if chain is enough
      always_ff @(posedge clock) begin
        if (rst) begin
          batch_cnt_q[g] <= '0;
          discard_cnt_q[g] <= '0;
        end else if (pend_disc[g]) begin
          discard_cnt_q[g] <= discard_cnt_q[g] + 1'b1; // [R7]
        end else if (bat_end) begin
          batch_cnt_q[g] <= batch_cnt_q[g] + 1'b1; // [R1]
        end
      end
    end
  endgenerate

  // Event pulse outputs registered
  always_ff @(posedge clock) begin
    if (rst) begin
      batch_done <= '0;
      batch_discard <= '0;
    end else begin
      batch_done <= pend_batch;
      batch_discard <= pend_disc;
    end
  end

  // Tracking gates: per channel, only while that channel is enabled
  logic [1:0] rx_run_d;
  logic [1:0] hd2_run_d;
  logic [1:0] orx_run_d;
  assign rx_run_d = pin_q[1:0] & {2{ctrl_q[CTRL_RX_QEC_EN]}}; // [R12] [R13] [R10]
  assign hd2_run_d = pin_q[1:0] & {2{ctrl_q[CTRL_HD2_EN]}}; // [R17]
  assign orx_run_d = pin_q[5:4] & {2{ctrl_q[CTRL_ORX_QEC_EN]}}; // [R18] [R19]

  // Feedback path picked by the block itself: ORx input when Tx
  // runs and host is not using ORx, else internal loopback
  tcwq_src_t tx_src_d;
  assign tx_src_d = (|pin_q[3:2] && !(|pin_q[5:4])) ? TCWQ_SRC_ORX : TCWQ_SRC_INTERNAL; // [R8]

  // Registered gate outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_qec_run <= '0;
      hd2_run <= '0;
      orx_qec_run <= '0;
      hd2_upper_side <= 1'b0;
      fb_source <= '0;
    end else begin
      rx_qec_run <= rx_run_d;
      hd2_run <= hd2_run_d;
      orx_qec_run <= orx_run_d;
      hd2_upper_side <= ctrl_q[CTRL_SIDE]; // [R16] [R15]
      fb_source <= {tx_src_d == TCWQ_SRC_ORX, 1'b1};
    end
  end

  // Register write
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      ctrl_q <= reg_wdata[3:0];
    end
  end

  // Read decode
  logic [31:0] rd_d;
  assign rd_d = (reg_addr == REG_CTRL) ? {28'h0, ctrl_q} :
    (reg_addr == REG_STATUS) ? {23'h0, qual_q, pin_q} :
    (reg_addr == REG_BATCHES) ? {batch_cnt_q[1], batch_cnt_q[0]} :
    (reg_addr == REG_DISCARDS) ? {discard_cnt_q[1], discard_cnt_q[0]} : 32'h0;

  // Read data in the cycle after the strobe only
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_d : 32'h0;
    end
  end

  // Checks below all run on the core clock and sleep during reset.
  // Gates are registered, so each is judged one edge after its pin.

  // Gate never runs on a disabled receiver
  AST_RX_GATE: assert property (@(posedge clock) disable iff (rst) // [R12]
    !pin_q[0] |=> !rx_qec_run[0])
    else $error("rx qec ran while disabled");

  // Second receiver held off on its own pin only
  AST_RX_GATE1: assert property (@(posedge clock) disable iff (rst) // [R13]
    !pin_q[1] |=> !rx_qec_run[1])
    else $error("rx qec ran on disabled second channel");

  // Enabled receiver with tracking on does run
  AST_RX_RUN: assert property (@(posedge clock) disable iff (rst) // [R10]
    pin_q[0] && ctrl_q[CTRL_RX_QEC_EN] |=> rx_qec_run[0])
    else $error("rx qec idle");

  // Harmonic tracking stops with its receiver
  AST_HD2_GATE: assert property (@(posedge clock) disable iff (rst) // [R17]
    !pin_q[1] |=> !hd2_run[1])
    else $error("hd2 ran while disabled");

  // Same for the first receiver
  AST_HD2_GATE0: assert property (@(posedge clock) disable iff (rst) // [R17]
    !pin_q[0] |=> !hd2_run[0])
    else $error("hd2 ran on disabled first channel");

  // Harmonic tracking runs whenever allowed
  AST_HD2_RUN: assert property (@(posedge clock) disable iff (rst) // [R17]
    pin_q[1] && ctrl_q[CTRL_HD2_EN] |=> hd2_run[1])
    else $error("hd2 idle");

  // Observation tracking confined to observation periods
  AST_ORX_GATE: assert property (@(posedge clock) disable iff (rst) // [R19]
    !pin_q[4] |=> !orx_qec_run[0])
    else $error("orx qec ran while disabled");

  // Second observation channel held off on its own pin only
  AST_ORX_GATE1: assert property (@(posedge clock) disable iff (rst) // [R19]
    !pin_q[5] |=> !orx_qec_run[1])
    else $error("orx qec ran on disabled second channel");

  // Observation tracking runs in the background when active
  AST_ORX_RUN: assert property (@(posedge clock) disable iff (rst) // [R18]
    pin_q[4] && ctrl_q[CTRL_ORX_QEC_EN] |=> orx_qec_run[0])
    else $error("orx qec idle");

  // Side output follows the control bit one edge later
  AST_SIDE: assert property (@(posedge clock) disable iff (rst) // [R16]
    hd2_upper_side == $past(ctrl_q[CTRL_SIDE]) || $past(rst))
    else $error("side mismatch");

  // Every receive-path discard event reaches the pulse output
  AST_DISC: assert property (@(posedge clock) disable iff (rst) // [R7]
    pend_disc[0] |=> batch_discard[0])
    else $error("discard lost");

  // Transmit path discards reach the output too
  AST_DISC_TX: assert property (@(posedge clock) disable iff (rst) // [R7]
    pend_disc[1] |=> batch_discard[1])
    else $error("tx discard lost");

  // Discards only happen at a fall, with the path low
  AST_DISC_LOW: assert property (@(posedge clock) disable iff (rst) // [R7]
    pend_disc[0] |-> !(pin_q[0] | pin_q[1]))
    else $error("discard while enabled");

  // A fall before the high minimum must discard
  AST_SHORT_DISC: assert property (@(posedge clock) disable iff (rst) // [R7]
    g_path[0].fall && !g_path[0].hi_ok |-> pend_disc[0])
    else $error("short period not discarded");

  // No batch straight after a rise
  AST_NO_EARLY_BATCH: assert property (@(posedge clock) disable iff (rst) // [R1]
    $rose(pin_q[0]) && !pin_q[1] |-> (!pend_batch[0]) [*8])
    else $error("batch too early");

  // Batch events reach the pulse output
  AST_DONE: assert property (@(posedge clock) disable iff (rst) // [R1]
    pend_batch[1] |=> batch_done[1])
    else $error("tx batch lost");

  // Batch pulse lasts one cycle; the next is a whole batch away
  AST_DONE_ONE: assert property (@(posedge clock) disable iff (rst) // [R1]
    batch_done[0] |=> !batch_done[0])
    else $error("batch pulse too long");

  // Interval counters saturate at the minimum, never wrap
  AST_HI_SAT: assert property (@(posedge clock) disable iff (rst) // [R20]
    g_path[0].hi_cnt_q <= CNT_W'(ENABLE_HIGH_MIN_CYC))
    else $error("high counter overran");

  // Low counter saturates the same way
  AST_LO_SAT: assert property (@(posedge clock) disable iff (rst) // [R20]
    g_path[0].lo_cnt_q <= CNT_W'(ENABLE_LOW_MIN_CYC))
    else $error("low counter overran");

  // Host owns the observation input: block keeps off it
  AST_FB: assert property (@(posedge clock) disable iff (rst) // [R8]
    (|pin_q[5:4]) |=> !fb_source[1])
    else $error("orx used while host owns it");

  // Transmit on and observation free: block takes the input
  AST_FB_TX: assert property (@(posedge clock) disable iff (rst) // [R8]
    (|pin_q[3:2]) && !(|pin_q[5:4]) |=> fb_source[1])
    else $error("orx input not taken");

  // Internal loopback is always offered outside reset
  AST_FB_INT: assert property (@(posedge clock) disable iff (rst) // [R8]
    1'b1 |=> fb_source[0])
    else $error("internal path missing");

  // Read data fall back to zero without a strobe
  AST_RDATA_IDLE: assert property (@(posedge clock) disable iff (rst)
    !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside its cycle");

endmodule // tcwq_top

// [hdl/tcwq_pkg.sv]
package tcwq_pkg;
  // Core clock rate
  localparam int CLK_FREQ_HZ = 100_000_000;
  // Batch length and enable minimum widths, in microseconds
  localparam int BATCH_US = 500;
  localparam int ENABLE_HIGH_MIN_US = 500;
  localparam int ENABLE_LOW_MIN_US = 500;
  // Cycle counts, clock rate in MHz rounded down
  localparam int BATCH_CYC = (BATCH_US * (CLK_FREQ_HZ / 1_000_000));
  localparam int ENABLE_HIGH_MIN_CYC = (ENABLE_HIGH_MIN_US * (CLK_FREQ_HZ / 1_000_000));
  localparam int ENABLE_LOW_MIN_CYC = (ENABLE_LOW_MIN_US * (CLK_FREQ_HZ / 1_000_000));
  // Interval counter width
  localparam int CNT_W = 20;
  // Register indices
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_BATCHES = 4'h2;
  localparam logic [3:0] REG_DISCARDS = 4'h3;
  // Control field positions
  localparam int CTRL_RX_QEC_EN = 0;
  localparam int CTRL_HD2_EN = 1;
  localparam int CTRL_ORX_QEC_EN = 2;
  localparam int CTRL_SIDE = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // Feedback source choice
  typedef enum logic {TCWQ_SRC_INTERNAL, TCWQ_SRC_ORX} tcwq_src_t;
endpackage

// [verification/tcwq_host_model.sv]
`timescale 1ns/1ps
// Baseband side: drives the channel enable pins as plain levels
module tcwq_host_model (
  input wire logic clock,
  output logic [1:0] rx_enable,
  output logic [1:0] tx_enable,
  output logic [1:0] orx_enable
);
  // All channels idle low from time zero
  initial begin
    rx_enable = 2'h0;
    tx_enable = 2'h0;
    orx_enable = 2'h0;
  end
  // Moves {rx, tx, orx} together just after an edge
  task automatic drive(input logic [5:0] en);
    @(posedge clock);
    {rx_enable, tx_enable, orx_enable} <= en;
  endtask
  // One enable window; ORx only when the bench lends it
  // External loop path assumed wired whenever Tx runs
  task automatic window(input logic [5:0] en, input int cyc);
    drive(en);
    repeat (cyc) @(posedge clock);
    drive(6'h00);
  endtask
endmodule // tcwq_host_model

// [verification/tcwq_top_tb.sv]
`timescale 1ns/1ps
// Table of gate cases, then reset and batch qualification by hand
module tcwq_top_tb;
  import tcwq_pkg::*;
  logic clock, rst, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  logic [1:0] rx_enable, tx_enable, orx_enable, rx_qec_run, hd2_run, orx_qec_run, fb_source;
  logic hd2_upper_side;
  logic [2:0] batch_done, batch_discard;
  int err_total, comparisons, cycles, n_done[3], n_disc[3];
  // Rows: control, {rx,tx,orx}, expected {rx_qec,hd2,orx_qec,fb,side}
  // HD2 rows stand for a supported receive profile
  logic [3:0] row_ctrl[4] = '{4'h7, 4'hF, 4'h1, 4'h6};
  logic [5:0] row_en[4] = '{6'h10, 6'h24, 6'h3F, 6'h01};
  logic [8:0] row_exp[4] = '{9'h0A2, 9'h147, 9'h182, 9'h00A};
  tcwq_top DUT (.clock(clock), .rst(rst), .rx_enable(rx_enable), .tx_enable(tx_enable),
    .orx_enable(orx_enable), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_qec_run(rx_qec_run), .hd2_run(hd2_run),
    .orx_qec_run(orx_qec_run), .hd2_upper_side(hd2_upper_side), .batch_done(batch_done),
    .batch_discard(batch_discard), .fb_source(fb_source));
  tcwq_host_model host (.clock(clock), .rx_enable(rx_enable), .tx_enable(tx_enable),
    .orx_enable(orx_enable));
  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Pulse tallies; the cycle ceiling stops a hang
  always @(posedge clock) begin
    cycles <= cycles + 1;
    for (int i = 0; i < 3; i++) begin
      n_done[i] <= rst ? 0 : n_done[i] + batch_done[i];
      n_disc[i] <= rst ? 0 : n_disc[i] + batch_discard[i];
    end
    if (cycles == 60000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  // Holds reset 16 cycles and checks the gates, pulses and read data bit 0 are quiet
  task automatic do_reset;
    @(posedge clock);
    rst <= 1'b1;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    #1 chk({hd2_upper_side, rx_qec_run, hd2_run, orx_qec_run, fb_source}, 32'h0);
    chk({batch_done, batch_discard, reg_rdata[0]}, 32'h0);
  endtask
  task automatic end_of_test;
    if (err_total == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {err_total, comparisons, cycles} = '0;
    do_reset();
    for (int r = 0; r < 4; r++) begin
      wr(REG_CTRL, {28'h0, row_ctrl[r]});
      host.drive(row_en[r]);
      repeat (4) @(posedge clock);
      #1 chk({rx_qec_run, hd2_run, orx_qec_run, fb_source, hd2_upper_side}, row_exp[r]);
    end
    // Control readback, then an unmapped index both ways
    wr(4'hF, 32'hFFFFFFFF);
    rd(REG_CTRL);
    chk(rd_val, 32'h6);
    @(posedge clock);
    #1 chk(reg_rdata, 32'h0);
    rd(4'hF);
    chk(rd_val, 32'h0);
    // Second reset mid-run clears the tallies from the table
    host.drive(6'h00);
    do_reset();
    host.window(6'h15, 50100);
    repeat (10) @(posedge clock);
    for (int i = 0; i < 3; i++) chk(n_done[i] * 2 + n_disc[i], 2);
    // Too short a window is thrown away at its fall
    host.window(6'h15, 100);
    repeat (10) @(posedge clock);
    for (int i = 0; i < 3; i++) chk(n_done[i] * 2 + n_disc[i], 3);
    rd(REG_BATCHES);
    chk(rd_val, 32'h00010001);
    rd(REG_DISCARDS);
    chk(rd_val, 32'h00010001);
    end_of_test();
  end
endmodule // tcwq_top_tb
